/* File: rtl/dper_params.svh */
// offsets, field positions, reset values and sizes of the direct page
`ifndef DPER_PARAMS_SVH
`define DPER_PARAMS_SVH
`define DPER_OFS_IND 5'h00
`define DPER_OFS_PARAM 5'h01
`define DPER_OFS_PAGE_POS 5'h02
`define DPER_OFS_MAILBOX 5'h03
`define DPER_OFS_SUM_HI 5'h04
`define DPER_OFS_SUM_LO 5'h05
`define DPER_OFS_BASE_HI 5'h06
`define DPER_OFS_BASE_LO 5'h07
`define DPER_OFS_CLKSEL_B 5'h08
`define DPER_OFS_CLKSEL_A 5'h09
`define DPER_OFS_CLK_HEALTH 5'h0A
`define DPER_OFS_REFCLK_CFG 5'h0B
`define DPER_OFS_FAULT_LIVE 5'h0C
`define DPER_OFS_FAULT_MASK 5'h0D
`define DPER_OFS_STRAP_HI 5'h14
`define DPER_OFS_STRAP_LO 5'h15
`define DPER_OFS_RESET_CAUSE 5'h16
`define DPER_OFS_ENTRY_HI 5'h18
`define DPER_OFS_ENTRY_LO 5'h19
`define DPER_REG_COUNT 32
`define DPER_DIRECT_LIMIT 7'h78
`define DPER_CMD_DIRECT_BIT 15
`define DPER_CMD_OFS_MSB 14
`define DPER_CMD_OFS_LSB 8
`define DPER_CMD_RW_BIT 7
`define DPER_CMD_LEN_MSB 6
`define DPER_ORIGIN_BIT 15
`define DPER_MAILBOX_BITS 16'h0003
`define DPER_CAUSE_BITS 16'h000F
`define DPER_WORD_RESET 16'h0000
`define DPER_QUEUE_DEPTH 4
`endif

/* File: rtl/dper_pkg.sv */
// types shared by the direct page event readout block
package dper_pkg;
	typedef logic [15:0] dper_word_t;
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} dper_hword_s;
	typedef struct packed {
		logic [14:0] code;
		logic [15:0] param;
	} dper_evt_s;
	typedef struct packed {
		logic wr;
		logic [4:0] addr;
		logic [15:0] data;
	} dper_fw_wr_s;
	typedef enum logic [1:0] {
		DPER_IDLE,
		DPER_DATA,
		DPER_SKIP
	} dper_parse_e;
endpackage : dper_pkg

/* File: rtl/dper_top.sv */
// direct page register block with interrupt indication readout
`timescale 1ns/10ps
`include "dper_params.svh"

module dper_top (
	input wire logic clk_in,
	input wire logic rst_in,
	// host bus side
	input wire logic frame_in,
	input wire dper_pkg::dper_hword_s host_word_in,
	// firmware side
	input wire dper_pkg::dper_evt_s evt_in,
	input wire logic evt_push_in,
	input wire logic [15:0] fault_state_in,
	input wire dper_pkg::dper_fw_wr_s fw_wr_in,
	input wire logic [4:0] fw_rd_addr_in,
	// registered outputs
	output logic [15:0] rd_data_out,
	output logic rd_valid_out,
	output logic irq_out,
	output logic evt_ready_out,
	output logic [15:0] fw_rd_data_out
);
	import dper_pkg::*;

	// direct page map, word offsets
	// each location is one 16-bit word
	// 0x00 irq indication, a read clears the reported event
	// 0x01 irq parameter, loaded by each indication read
	// 0x02 page position, host read-write
	// 0x03 mailbox ownership, host can only set bits 1:0
	// 0x04-0x05 boot sum high and low
	// 0x06-0x07 load window base high and low
	// 0x08-0x09 highway b and a clock selects
	// 0x0A clock health, firmware supplied, host read only
	// 0x0B reference clock config
	// 0x0C live fault state, straight from the input
	// 0x0D fault irq mask, a set bit hides that fault
	// 0x0E-0x13 unused, read zero
	// 0x14-0x15 strap levels high and low, firmware supplied
	// 0x16 last reset cause, four bits kept
	// 0x17 unused, read zero
	// 0x18-0x19 program entry high and low
	// 0x1A-0x1F unused, read zero
	// 0x20 and up read zero
	// direct access refuses start offsets of 0x78 and up

	localparam int QW = $clog2(`DPER_QUEUE_DEPTH);

	// host may write only the plain read-write locations
	function automatic logic host_writable(input logic [4:0] a);
		case (a)
			`DPER_OFS_PAGE_POS,
			`DPER_OFS_MAILBOX,
			`DPER_OFS_SUM_HI,
			`DPER_OFS_SUM_LO,
			`DPER_OFS_BASE_HI,
			`DPER_OFS_BASE_LO,
			`DPER_OFS_CLKSEL_B,
			`DPER_OFS_CLKSEL_A,
			`DPER_OFS_REFCLK_CFG,
			`DPER_OFS_FAULT_MASK,
			`DPER_OFS_ENTRY_HI,
			`DPER_OFS_ENTRY_LO: begin
				host_writable = 1'b1;
			end
			default: begin
				host_writable = 1'b0;
			end
		endcase
	endfunction : host_writable

	// locations that hold a stored word at all
	function automatic logic is_mapped(input logic [4:0] a);
		case (a)
			`DPER_OFS_CLK_HEALTH,
			`DPER_OFS_STRAP_HI,
			`DPER_OFS_STRAP_LO,
			`DPER_OFS_RESET_CAUSE: begin
				is_mapped = 1'b1;
			end
			default: begin
				is_mapped = host_writable(a);
			end
		endcase
	endfunction : is_mapped

	// direct page words; 0 and 1 are shown by the indication logic
	dper_word_t regs_q [`DPER_REG_COUNT];

	// frame parser
	dper_parse_e state_q;
	logic [6:0] addr_q;
	logic [6:0] left_q;
	logic write_q;

	// indication side
	dper_word_t param_q;
	dper_word_t fault_prev_q;
	logic armed_q;
	logic [14:0] fault_pend_q;

	// event queue; head_q oldest entry, tail_q next free place
	// count_q is one bit wider so that full and empty differ
	dper_evt_s queue_q [`DPER_QUEUE_DEPTH];
	logic [QW-1:0] head_q;
	logic [QW-1:0] tail_q;
	logic [QW:0] count_q;

	// host frame: command word, then length+1 data words
	// command bit 15 set selects direct access, else skipped
	// bits 14:8 start offset, bit 7 write, bits 6:0 length
	// the address steps once per data word; extra words ignored
	// words may come back to back, one per valid pulse
	// frame_in low between frames returns the parser to idle
	// reads answer one cycle after their slot, one word per slot

	// host word decode
	// cur_addr drops bits 6:5; in_page guards the upper range
	wire logic word_go = frame_in && host_word_in.valid;
	wire logic in_data = word_go && state_q == DPER_DATA;
	wire logic [4:0] cur_addr = addr_q[4:0];
	wire logic in_page = addr_q < 7'h20;
	wire logic host_wr = in_data && write_q && in_page
		&& host_writable(cur_addr);
	wire logic host_rd = in_data && !write_q;
	wire logic ind_rd = host_rd && addr_q == 7'(`DPER_OFS_IND);
	wire logic [6:0] cmd_ofs =
		host_word_in.data[`DPER_CMD_OFS_MSB:`DPER_CMD_OFS_LSB];
	wire logic cmd_direct = host_word_in.data[`DPER_CMD_DIRECT_BIT]
		&& cmd_ofs < `DPER_DIRECT_LIMIT;

	// indication source choice: unmasked fault edges first,
	// then the oldest queued event, else an all-zero word
	// fault priority keeps a flood of events from hiding faults
	// a fault parameter is the live fault word at the read,
	// not the word at the edge, so the host sees the current state
	// timing seen by the host
	// edge n samples a fault change or a push; it latches there
	// irq_out follows after edge n+1
	// an indication slot taken at edge m clears or pops at m,
	// and its word stands on rd_data_out from edge m on
	// irq_out drops after edge m+1 when nothing else waits
	// pending sources; fault transitions take precedence over the queue
	wire logic [14:0] fault_edge = armed_q
		? (fault_state_in[14:0] ^ fault_prev_q[14:0]) : 15'h0000;
	wire logic [14:0] unmasked =
		fault_pend_q & ~regs_q[`DPER_OFS_FAULT_MASK][14:0];
	wire logic fault_any = |unmasked;
	wire logic queue_any = count_q != '0;
	wire dper_evt_s q_head = queue_q[head_q];
	wire dper_word_t ind_word = fault_any ? {1'b1, unmasked}
		: queue_any ? {1'b0, q_head.code}
		: `DPER_WORD_RESET;
	wire dper_word_t ind_param = fault_any ? fault_state_in
		: queue_any ? q_head.param : `DPER_WORD_RESET;
	wire logic fault_clr = ind_rd && fault_any;
	wire logic pop = ind_rd && !fault_any && queue_any;
	wire logic push = evt_push_in
		&& count_q != (QW+1)'(`DPER_QUEUE_DEPTH);
	wire logic [QW:0] count_next = count_q + (QW+1)'(push) - (QW+1)'(pop);

	// read mux; reserved and unmapped locations read zero
	wire dper_word_t stored = is_mapped(cur_addr) ? regs_q[cur_addr]
		: `DPER_WORD_RESET;
	wire dper_word_t rd_mux = !in_page ? `DPER_WORD_RESET
		: cur_addr == `DPER_OFS_IND ? ind_word
		: cur_addr == `DPER_OFS_PARAM ? param_q
		: cur_addr == `DPER_OFS_FAULT_LIVE ? fault_state_in
		: stored;

	// a dropped frame_in aborts mid-command; its words are lost
	// a refused command still eats its words so nothing lands
	// frame parser for direct offset access; other commands pass by
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= DPER_IDLE;
			addr_q <= 7'h00;
			left_q <= 7'h00;
			write_q <= 1'b0;
		end else if (!frame_in) begin
			state_q <= DPER_IDLE;
		end else if (host_word_in.valid) begin
			case (state_q)
				DPER_IDLE: begin
					state_q <= cmd_direct ? DPER_DATA : DPER_SKIP;
					addr_q <= cmd_ofs;
					write_q <= host_word_in.data[`DPER_CMD_RW_BIT];
					left_q <= host_word_in.data[`DPER_CMD_LEN_MSB:0];
				end
				DPER_DATA: begin
					addr_q <= addr_q + 7'h01;
					left_q <= left_q - 7'h01;
					if (left_q == 7'h00) begin
						state_q <= DPER_SKIP;
					end
				end
				default: begin
					state_q <= DPER_SKIP;
				end
			endcase
		end
	end

	// rd_data_out keeps its word between reads, so a slow host
	// can still pick it up after rd_valid_out has dropped
	// writes never touch rd_data_out
	// read answer one cycle after the slot
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_out <= `DPER_WORD_RESET;
			rd_valid_out <= 1'b0;
		end else begin
			rd_valid_out <= host_rd;
			if (host_rd) begin
				rd_data_out <= rd_mux;
			end
		end
	end

	// a parameter read leaves this latch alone
	// an empty indication read loads zero here
	// reset is the only other way to change it
	// parameter latch, reloaded on every indication read
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			param_q <= `DPER_WORD_RESET;
		end else if (ind_rd) begin
			param_q <= ind_param;
		end
	end

	// after reset: evt_ready_out rises on the first edge, while
	// irq_out and rd_valid_out stay low and every stored word reads zero; 0x0C follows fault_state_in
	// armed_q holds off edges until a baseline exists, else the
	// first sample after reset would look like a transition
	// fault transition capture; a new edge wins over the read clear
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			fault_prev_q <= `DPER_WORD_RESET;
			armed_q <= 1'b0;
		end else begin
			fault_prev_q <= fault_state_in;
			armed_q <= 1'b1; // first sample is a baseline, not an edge
		end
	end

	genvar b;
	generate
		for (b = 0; b < 15; b++) begin : g_fault
			// a new edge in the clear cycle keeps the bit set, so a
			// fault that bounces during the read is reported again
			// the mask only hides; it never clears a latched bit
			// masked bits stay latched and show once unmasked
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					fault_pend_q[b] <= 1'b0;
				end else if (fault_edge[b]) begin
					fault_pend_q[b] <= 1'b1;
				end else if (fault_clr && unmasked[b]) begin
					fault_pend_q[b] <= 1'b0;
				end
			end
		end
	endgenerate

	// push and pop may share a cycle; the count then stays
	// a pop only when no fault is shown, matching the read word
	// pointers wrap freely; count_q alone tells full from empty
	// firmware event queue; full refuses pushes via evt_ready_out
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			head_q <= '0;
			tail_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				tail_q <= tail_q + 1'b1;
			end
			if (pop) begin
				head_q <= head_q + 1'b1;
			end
			count_q <= count_next;
		end
	end

	// storage has no reset; entries are only read below count_q
	// saves a reset tree on the widest flops of the block
	always_ff @(posedge clk_in) begin
		if (push) begin
			queue_q[tail_q] <= evt_in;
		end
	end

	// ready follows the next count so a full queue shows at once
	// irq follows the pending state one cycle late
	// the live fault word bypasses storage on both read paths
	// readiness, interrupt line and firmware readback
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			evt_ready_out <= 1'b0;
			irq_out <= 1'b0;
			fw_rd_data_out <= `DPER_WORD_RESET;
		end else begin
			evt_ready_out <= count_next != (QW+1)'(`DPER_QUEUE_DEPTH);
			irq_out <= fault_any || queue_any;
			fw_rd_data_out <= fw_rd_addr_in == `DPER_OFS_FAULT_LIVE
				? fault_state_in : regs_q[fw_rd_addr_in];
		end
	end

	// host and firmware may hit one word together; host wins
	// unused locations never load and stay at their reset zero
	// offsets 0 and 1 are never loaded; the indication logic answers
	// mailbox: host hands a box over, firmware writes bits whole
	// register words; host writes win, mailbox bits are write-one-to-set
	genvar r;
	generate
		for (r = 0; r < `DPER_REG_COUNT; r++) begin : g_reg
			wire logic hit_h = host_wr && cur_addr == 5'(r);
			wire logic hit_f = fw_wr_in.wr && fw_wr_in.addr == 5'(r);
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					regs_q[r] <= `DPER_WORD_RESET;
				end else if (r == `DPER_OFS_MAILBOX) begin
					if (hit_h) begin
						regs_q[r] <= regs_q[r] | (host_word_in.data
							& `DPER_MAILBOX_BITS);
					end else if (hit_f) begin
						regs_q[r] <= fw_wr_in.data & `DPER_MAILBOX_BITS;
					end
				end else if (hit_h) begin
					regs_q[r] <= host_word_in.data;
				// firmware fills the read-only words; cause keeps four bits
				end else if (hit_f && is_mapped(5'(r))) begin
					regs_q[r] <= r == `DPER_OFS_RESET_CAUSE
						? fw_wr_in.data & `DPER_CAUSE_BITS
						: fw_wr_in.data;
				end
			end
		end
	endgenerate

	// limitations
	// paged, start, continue, select and setup commands are skipped
	// whole; only direct offset access reaches this page
	// the queue holds four events; a push while full is lost,
	// so firmware must watch evt_ready_out before pushing
	// fault bit 15 is never reported as a transition
	// strap and cause words read zero until firmware writes; entry words until either side writes
	// reserved bits are stored as written except in the mailbox and cause words; hosts keep them zero
	// a firmware write loses to a host write of the same word
	// no mailbox storage lives here; only the ownership flags do

endmodule : dper_top

/* File: tb/dper_host.sv */
// host processor model issuing direct offset frames
`timescale 1ns/10ps
module dper_host (
	input wire logic clk_in,
	input wire logic [15:0] rd_data_in,
	input wire logic rd_valid_in,
	output logic frame_out,
	output dper_pkg::dper_hword_s word_out
);
	import dper_pkg::*;
	logic [15:0] rq[$];
	initial begin
		frame_out = 1'b0;
		word_out = '0;
	end
	// answers stand one cycle, so look at every falling edge
	always @(negedge clk_in) begin
		if (rd_valid_in === 1'b1) begin
			rq.push_back(rd_data_in);
		end
	end
	// command then length+1 words; read slots carry a changing filler
	task automatic xfer(input logic [15:0] cmd, input logic [15:0] wd);
		int i;
		@(negedge clk_in);
		frame_out = 1'b1;
		word_out = {1'b1, cmd};
		for (i = 0; i <= int'(cmd[6:0]); i++) begin
			@(negedge clk_in);
			word_out = {1'b1, cmd[7] ? wd : 16'(~i)};
		end
		@(negedge clk_in);
		word_out = '0;
		@(negedge clk_in);
		frame_out = 1'b0;
	endtask : xfer
endmodule : dper_host

/* File: tb/dper_chk.sv */
// port checks for the direct page event readout block
`timescale 1ns/10ps
module dper_chk (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic frame_in,
	input wire dper_pkg::dper_hword_s host_word_in,
	input wire logic evt_push_in,
	input wire logic [15:0] fault_state_in,
	input wire logic [15:0] rd_data_out,
	input wire logic rd_valid_out,
	input wire logic irq_out,
	input wire logic evt_ready_out
);
	import dper_pkg::*;
	logic [2:0] tz_q, tz_d, cz_q, cz_d;
	logic [15:0] f_q;
	logic took, cause;
	// ages since a host word and since any possible irq cause, saturating
	assign took = frame_in & host_word_in.valid;
	assign cause = evt_push_in | took | (fault_state_in != f_q);
	assign tz_d = took ? 3'h0 : tz_q + {2'h0, tz_q != 3'h7};
	assign cz_d = cause ? 3'h0 : cz_q + {2'h0, cz_q != 3'h7};
	// reset to zero so the wake-up edges count as caused
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tz_q <= 3'h0;
			cz_q <= 3'h0;
			f_q <= 16'h0000;
		end else begin
			tz_q <= tz_d;
			cz_q <= cz_d;
			f_q <= fault_state_in;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_valid_src; rd_valid_out |-> $past(took); endproperty
	a_valid_src: assert property (p_valid_src)
		else $error("read answer without a host word");
	property p_data_hold; !rd_valid_out |-> $stable(rd_data_out); endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("read data moved outside a read slot");
	property p_irq_cause; $rose(irq_out) |-> cz_q <= 3'h3; endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("irq rose with no cause");
	property p_irq_clear; $fell(irq_out) |-> tz_q <= 3'h3; endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("irq dropped without a read");
	property p_ready_free; $rose(evt_ready_out) |-> tz_q <= 3'h3; endproperty
	a_ready_free: assert property (p_ready_free)
		else $error("queue space freed without a read");
	property p_full_pend; $fell(evt_ready_out) |-> irq_out; endproperty
	a_full_pend: assert property (p_full_pend)
		else $error("full queue but irq low");
	property p_ready_drop; $fell(evt_ready_out) |-> cz_q <= 3'h3; endproperty
	a_ready_drop: assert property (p_ready_drop)
		else $error("queue filled with no push");
	property p_push_irq;
		evt_push_in && evt_ready_out |-> ##[1:3] irq_out;
	endproperty
	a_push_irq: assert property (p_push_irq)
		else $error("push did not raise irq");
	c_irq: cover property ($rose(irq_out));
	c_full: cover property ($fell(evt_ready_out));
	c_burst: cover property (rd_valid_out [*2]);
endmodule : dper_chk
bind dper_top dper_chk CHK (.clk_in, .rst_in, .frame_in, .host_word_in,
	.evt_push_in, .fault_state_in, .rd_data_out, .rd_valid_out, .irq_out,
	.evt_ready_out);

/* File: tb/dper_top_tb.sv */
// self-checking bench for the direct page event readout block
`timescale 1ns/10ps
module dper_top_tb;
	import dper_pkg::*;
	typedef struct {logic [6:0] a; logic [15:0] w; logic [15:0] e;} dper_row_s;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic evt_push_in = 1'b0;
	logic frame_in, rd_valid_out, irq_out, evt_ready_out;
	dper_hword_s host_word_in;
	dper_evt_s evt_in = '0;
	dper_fw_wr_s fw_wr_in = '0;
	logic [15:0] fault_state_in = 16'h0000;
	logic [15:0] rd_data_out, fw_rd_data_out;
	logic [4:0] fw_rd_addr_in = 5'h00;
	int n_fail = 0;
	int tests_run = 0;
	int i;
	// write, read back; read-only and unmapped places keep zero
	dper_row_s rows [12] = '{'{7'h02, 16'h0155, 16'h0155},
		'{7'h03, 16'h0003, 16'h0003}, '{7'h04, 16'hA5A5, 16'hA5A5},
		'{7'h05, 16'h5A5A, 16'h5A5A}, '{7'h06, 16'h1234, 16'h1234},
		'{7'h07, 16'hAB00, 16'hAB00}, '{7'h08, 16'h0F0F, 16'h0F0F},
		'{7'h0A, 16'hFFFF, 16'h0000}, '{7'h0C, 16'hFFFF, 16'h0000},
		'{7'h10, 16'hFFFF, 16'h0000}, '{7'h16, 16'h000F, 16'h0000},
		'{7'h18, 16'hBEEF, 16'hBEEF}};
	always #12.5 clk_in = ~clk_in;
	dper_host HOST (.clk_in(clk_in), .rd_data_in(rd_data_out),
		.rd_valid_in(rd_valid_out), .frame_out(frame_in),
		.word_out(host_word_in));
	dper_top DUT (.clk_in(clk_in), .rst_in(rst_in), .frame_in(frame_in),
		.host_word_in(host_word_in), .evt_in(evt_in),
		.evt_push_in(evt_push_in), .fault_state_in(fault_state_in),
		.fw_wr_in(fw_wr_in), .fw_rd_addr_in(fw_rd_addr_in),
		.rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
		.irq_out(irq_out), .evt_ready_out(evt_ready_out),
		.fw_rd_data_out(fw_rd_data_out));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	// a missing answer compares as unknown and so fails
	task automatic take(input logic [15:0] e);
		chk(HOST.rq.size() > 0 ? HOST.rq.pop_front() : 'x, e);
	endtask : take
	task automatic rd(input logic [6:0] a, input logic [6:0] n);
		HOST.rq.delete();
		HOST.xfer({1'b1, a, 1'b0, n}, 16'h0000);
		repeat (2) @(negedge clk_in);
	endtask : rd
	task automatic wr(input logic [6:0] a, input logic [15:0] w);
		HOST.xfer({1'b1, a, 1'b1, 7'h00}, w);
	endtask : wr
	task close_out;
		if (n_fail == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out
	// a hang ends the run as a mismatch
	initial begin
		#200000;
		n_fail++;
		close_out();
	end
	initial begin
		repeat (10) @(negedge clk_in);
		rst_in = 1'b0;
		repeat (3) @(negedge clk_in);
		chk({14'h0000, evt_ready_out, irq_out}, 16'h0002);
		rd(7'h14, 7'h02);
		for (i = 0; i < 3; i++) begin
			take(16'h0000);
		end
		for (i = 0; i < 12; i++) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, 7'h00);
			take(rows[i].e);
		end
		rd(7'h04, 7'h03);
		for (i = 2; i < 6; i++) begin
			take(rows[i].e);
		end
		// host zeros leave mailbox bits set
		wr(7'h03, 16'h0000);
		rd(7'h03, 7'h00);
		take(16'h0003);
		// firmware fills cause and straps; cause keeps four bits
		fw_wr_in = '{1'b1, 5'h16, 16'hFFF5};
		@(negedge clk_in);
		fw_wr_in = '{1'b1, 5'h14, 16'h1357};
		@(negedge clk_in);
		fw_wr_in = '{1'b1, 5'h03, 16'hFFFE};
		@(negedge clk_in);
		fw_wr_in = '0;
		fw_rd_addr_in = 5'h18;
		rd(7'h14, 7'h02);
		take(16'h1357);
		take(16'h0000);
		take(16'h0005);
		rd(7'h03, 7'h00);
		take(16'h0002);
		chk(fw_rd_data_out, 16'hBEEF);
		// five back to back pushes into four places; the last is dropped
		for (i = 0; i < 5; i++) begin
			evt_in = '{15'(i + 1), 16'(32'h0100 + i)};
			evt_push_in = 1'b1;
			@(negedge clk_in);
		end
		evt_push_in = 1'b0;
		@(negedge clk_in);
		chk({14'h0000, evt_ready_out, irq_out}, 16'h0001);
		rd(7'h01, 7'h00);
		take(16'h0000);
		for (i = 0; i < 4; i++) begin
			rd(7'h00, 7'h01);
			take({1'b0, 15'(i + 1)});
			take(16'(32'h0100 + i));
		end
		rd(7'h00, 7'h01);
		take(16'h0000);
		take(16'h0000);
		chk({15'h0000, irq_out}, 16'h0000);
		// bit 1 masked; bit 15 lies outside the transition field
		wr(7'h0D, 16'h0002);
		fault_state_in = 16'h8003;
		repeat (4) @(negedge clk_in);
		chk({15'h0000, irq_out}, 16'h0001);
		rd(7'h00, 7'h01);
		take(16'h8001);
		take(16'h8003);
		rd(7'h01, 7'h00);
		take(16'h8003);
		rd(7'h00, 7'h00);
		take(16'h0000);
		chk({15'h0000, irq_out}, 16'h0000);
		close_out();
	end
endmodule : dper_top_tb
